// File: pdu_cpu_model.sv
// cpu core model: issues register reads and writes on the 4-bit bus
// assumes the unit takes strobes on the rising edge of mclk
`timescale 1ns/1ps
module pdu_cpu_model (
	input  wire logic         mclk,
	output pdu_pkg::pdu_bus_s cpu_bus,
	input  wire logic [3:0]   rdata
);
	logic [3:0] taken;
	initial cpu_bus = '0;
	always_ff @(posedge mclk) begin
		if (cpu_bus.rd) begin
			taken <= rdata;
		end
	end
	// one strobe per call; released lines show inverted data, never the last value
	task automatic xfer(input logic w, input logic [3:0] num, input logic [3:0] d,
		output logic [3:0] q);
		@(posedge mclk);
		#1;
		cpu_bus = {~w, w, num, d};
		@(posedge mclk);
		#1;
		q = taken;
		cpu_bus = {2'b00, ~num, ~d};
	endtask : xfer
endmodule : pdu_cpu_model

// File: pdu_defines.svh
// constants for the port / display / divider unit
// assumes inclusion by the package and the design modules only
`ifndef PDU_DEFINES_SVH
`define PDU_DEFINES_SVH
`define PDU_REG_GEN_OUT      4'h1
`define PDU_REG_IO_A         4'h2
`define PDU_REG_IO_B         4'h4
`define PDU_REG_DIGIT_KEY    4'h5
`define PDU_REG_SEG_CBUF     4'h6
`define PDU_REG_SEG_HIGH     4'h7
`define PDU_OUT_RESET        4'h0
`define PDU_DIV_STAGES       16
`define PDU_PRESCALE_STAGES  6
`define PDU_DIV2_WRAP        14'h30D4
`define PDU_SYNC_STAGES      3
`define PDU_CBUF_MSB         3
`define PDU_IOB_SPLIT_LOW    2
`endif

// File: pdu_divider.sv
// prescaler, 16-stage counting divider and timing output
// assumes one clock mclk; basic clock is an enable pulse, not a clock
`timescale 1ns/1ps
`include "pdu_defines.svh"
module pdu_divider #(
	parameter int          PRESCALE_RATIO = 2,
	parameter logic [3:0]  TIMING_TAP     = 4'h5,
	parameter bit          USE_TIMING_CP  = 1'b0,
	parameter bit          WRAP_12500     = 1'b0
) (
	input  wire logic                        mclk,
	input  wire logic                        reset_n,
	output logic                             basic_clock,
	output logic [`PDU_DIV_STAGES-1:0]       div_stages,
	output logic                             timing_out_pin
);
	logic [`PDU_PRESCALE_STAGES-1:0] prescale;
	logic [`PDU_DIV_STAGES-1:0]      next_div;
	// prescaler ratio fixed at build time
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prescale    <= '0;
			basic_clock <= 1'b0;
		end else if (prescale == 6'(PRESCALE_RATIO - 1)) begin
			prescale    <= '0;
			basic_clock <= 1'b1;
		end else begin
			prescale    <= prescale + 6'h01;
			basic_clock <= 1'b0;
		end
	end
	// synchronous equivalent of a ripple chain; low section stages 0..1
	always_comb begin
		next_div = div_stages + 16'h0001;
		// second section wraps at its count value
		if (WRAP_12500 && (div_stages[15:2] == `PDU_DIV2_WRAP) && (div_stages[1:0] == 2'h3)) begin
			next_div = 16'h0000;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_stages <= '0;
		end else if (basic_clock) begin
			div_stages <= next_div;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timing_out_pin <= 1'b0;
		end else begin
			timing_out_pin <= USE_TIMING_CP ? basic_clock : div_stages[TIMING_TAP];
		end
	end
	property p_div_steps;
		@(posedge mclk) disable iff (!reset_n)
		(basic_clock && !WRAP_12500) |=> (div_stages == $past(div_stages) + 16'h0001);
	endproperty
	a_div_steps : assert property (p_div_steps)
		else $error("divider did not count on basic clock");
endmodule : pdu_divider

// File: pdu_pkg.sv
// types shared by the port / display / divider unit
// assumes pdu_defines.svh is on the include path
`include "pdu_defines.svh"
package pdu_pkg;
	typedef logic [3:0] pdu_nib_t;
	typedef enum logic [1:0] {
		PDU_IOB_OUT   = 2'b00,
		PDU_IOB_IN    = 2'b01,
		PDU_IOB_SPLIT = 2'b10
	} pdu_iob_mode_e;
	typedef struct packed {
		logic     rd;
		logic     wr;
		pdu_nib_t regnum;
		pdu_nib_t wdata;
	} pdu_bus_s;
	typedef struct packed {
		pdu_nib_t gen_out_port;
		pdu_nib_t cfg_io_port_a;
		pdu_nib_t cfg_io_port_b;
		logic [4:0] digit_out_port;
		logic [7:0] segment_out_port;
	} pdu_pins_s;
endpackage : pdu_pkg

// File: pdu_port_unit.sv
// register-numbered port unit: outputs, io ports, display, counter buffer
// assumes cpu strobes are one-cycle pulses synchronous to mclk
// Function
// - register 1 holds and drives general output
// - reading register 1 returns held value
// - registers 2 and 4 select configurable ports
// - port b out, in or split; a independent
// - input bits read unlatched; outputs readable back
// - write 5 decodes nibble to 5-bit digit
// - digit register unreadable; read 5 gives keys
// - key input sampled on read of 5
// - write 6 looks up 16x8 segment table
// - split mode: 7 high nibble, 6 low
// - segment registers are write only
// - read 6 gives pin plus three taps
// - single input synchronised, three half-periods max
// - sixteen-stage divider counts basic clock
// - counter buffer taps chosen at build
// - top buffer bit enables hold release
// - 100 kHz option wraps second section at 12500
// - six-stage prescaler makes basic clock
// - timing output frequency chosen at build
// - output registers clear on initialise
`timescale 1ns/1ps
`include "pdu_defines.svh"
module pdu_port_unit #(
	parameter bit                    IO_A_IS_OUTPUT = 1'b1,
	parameter pdu_pkg::pdu_iob_mode_e IO_B_MODE     = pdu_pkg::PDU_IOB_OUT,
	parameter bit                    SEG_SPLIT      = 1'b0,
	parameter logic [39:0]           DIGIT_TABLE    = 40'h0000000000,
	parameter logic [127:0]          SEG_TABLE      = 128'h0,
	parameter logic [3:0]            TAP_1          = 4'h9,
	parameter logic [3:0]            TAP_2          = 4'hA,
	parameter logic [3:0]            TAP_3          = 4'hB,
	parameter int                    PRESCALE_RATIO = 2,
	parameter logic [3:0]            TIMING_TAP     = 4'h5,
	parameter bit                    USE_TIMING_CP  = 1'b0,
	parameter bit                    WRAP_12500     = 1'b0
) (
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire pdu_pkg::pdu_bus_s  cpu_bus,
	output logic [3:0]              rdata,
	input  wire logic [3:0]         io_a_in,
	input  wire logic [3:0]         io_b_in,
	input  wire logic [3:0]         key_in_port,
	input  wire logic               single_in_pin,
	output pdu_pkg::pdu_pins_s      pins,
	output logic [3:0]              io_a_oe,
	output logic [3:0]              io_b_oe,
	output logic                    timing_out_pin,
	output logic                    hold_release_en
);
	logic [3:0]                   gen_out_port;
	logic [3:0]                   cfg_io_port_a;
	logic [3:0]                   cfg_io_port_b;
	logic [4:0]                   digit_out_port;
	logic [7:0]                   segment_out_port;
	logic [`PDU_SYNC_STAGES-1:0]  in_sync;
	logic                         basic_clock;
	logic [`PDU_DIV_STAGES-1:0]   div_stages;
	logic [3:0]                   cbuf;
	logic [3:0]                   b_in_mask;
	logic                         wr_gen;
	logic                         wr_a;
	logic                         wr_b;
	logic                         wr_digit;
	logic                         wr_seg;
	logic                         wr_seg_hi;
	logic [7:0]                   seg_lookup;
	logic [4:0]                   digit_lookup;
	logic [`PDU_PRESCALE_STAGES-1:0] cp_age;
	logic                         half_tick;

	pdu_divider #(
		.PRESCALE_RATIO (PRESCALE_RATIO),
		.TIMING_TAP     (TIMING_TAP),
		.USE_TIMING_CP  (USE_TIMING_CP),
		.WRAP_12500     (WRAP_12500)
	) u_div (
		.mclk           (mclk),
		.reset_n        (reset_n),
		.basic_clock    (basic_clock),
		.div_stages     (div_stages),
		.timing_out_pin (timing_out_pin)
	);

	// direction of strobe is part of the decode
	assign wr_gen    = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_GEN_OUT);
	assign wr_a      = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_IO_A);
	assign wr_b      = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_IO_B);
	assign wr_digit  = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_DIGIT_KEY);
	assign wr_seg    = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_SEG_CBUF);
	assign wr_seg_hi = cpu_bus.wr && (cpu_bus.regnum == `PDU_REG_SEG_HIGH) && SEG_SPLIT;

	// mask-style tables: each entry a constant slice
	assign digit_lookup = DIGIT_TABLE[cpu_bus.wdata*5 +: 5];
	assign seg_lookup   = SEG_TABLE[cpu_bus.wdata*8 +: 8];

	// fixed by build options, never by software
	assign b_in_mask = (IO_B_MODE == pdu_pkg::PDU_IOB_IN)    ? 4'hF :
	                   (IO_B_MODE == pdu_pkg::PDU_IOB_SPLIT) ? 4'hC : 4'h0;
	assign io_a_oe   = IO_A_IS_OUTPUT ? 4'hF : 4'h0;
	assign io_b_oe   = ~b_in_mask;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gen_out_port <= `PDU_OUT_RESET;
		end else if (wr_gen) begin
			gen_out_port <= cpu_bus.wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_io_port_a <= `PDU_OUT_RESET;
			cfg_io_port_b <= `PDU_OUT_RESET;
		end else begin
			if (wr_a) begin
				cfg_io_port_a <= cpu_bus.wdata;
			end
			if (wr_b) begin
				cfg_io_port_b <= cpu_bus.wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			digit_out_port <= 5'h00;
		end else if (wr_digit) begin
			digit_out_port <= digit_lookup;
		end
	end

	// split mode bypasses the table: plain nibbles
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			segment_out_port <= 8'h00;
		end else if (SEG_SPLIT) begin
			if (wr_seg) begin
				segment_out_port[3:0] <= cpu_bus.wdata;
			end
			if (wr_seg_hi) begin
				segment_out_port[7:4] <= cpu_bus.wdata;
			end
		end else if (wr_seg) begin
			segment_out_port <= seg_lookup;
		end
	end

	// half-period ticks of the basic clock; odd ratios put the mid tick early
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cp_age <= '0;
		end else if (basic_clock) begin
			cp_age <= 6'h01;
		end else begin
			cp_age <= cp_age + 6'h01;
		end
	end
	assign half_tick = basic_clock || (cp_age == 6'(PRESCALE_RATIO / 2));

	// shaping register steps each half period, so faster pulses are lost
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			in_sync <= '0;
		end else if (half_tick) begin
			in_sync <= {in_sync[`PDU_SYNC_STAGES-2:0], single_in_pin};
		end
	end

	// taps picked per oscillator option
	assign cbuf = {div_stages[TAP_3], div_stages[TAP_2], div_stages[TAP_1],
	               in_sync[`PDU_SYNC_STAGES-1]};
	assign hold_release_en = cbuf[`PDU_CBUF_MSB];

	// unlatched reads: value of the cycle of the strobe
	always_comb begin
		rdata = 4'h0;
		if (cpu_bus.rd) begin
			case (cpu_bus.regnum)
				`PDU_REG_GEN_OUT:   rdata = gen_out_port;
				`PDU_REG_IO_A:      rdata = IO_A_IS_OUTPUT ? cfg_io_port_a : io_a_in;
				`PDU_REG_IO_B:      rdata = (io_b_in & b_in_mask) |
				                            (cfg_io_port_b & ~b_in_mask);
				`PDU_REG_DIGIT_KEY: rdata = key_in_port;
				`PDU_REG_SEG_CBUF:  rdata = cbuf;
				default:            rdata = 4'h0; // register 7 not readable
			endcase
		end
	end

	assign pins.gen_out_port     = gen_out_port;
	assign pins.cfg_io_port_a    = cfg_io_port_a;
	assign pins.cfg_io_port_b    = cfg_io_port_b;
	assign pins.digit_out_port   = digit_out_port;
	assign pins.segment_out_port = segment_out_port;

	property p_gen_write;
		@(posedge mclk) disable iff (!reset_n)
		wr_gen |=> (pins.gen_out_port == $past(cpu_bus.wdata));
	endproperty
	a_gen_write : assert property (p_gen_write)
		else $error("general output not loaded");

	property p_gen_read;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_GEN_OUT) |-> (rdata == pins.gen_out_port);
	endproperty
	a_gen_read : assert property (p_gen_read)
		else $error("general output readback wrong");

	property p_iob_dir;
		@(posedge mclk) disable iff (!reset_n)
		(io_b_oe == ~b_in_mask) && (IO_B_MODE != pdu_pkg::PDU_IOB_SPLIT || io_b_oe == 4'h3);
	endproperty
	a_iob_dir : assert property (p_iob_dir)
		else $error("port b direction wrong");

	property p_iob_read;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_IO_B) |->
			((rdata & b_in_mask) == (io_b_in & b_in_mask));
	endproperty
	a_iob_read : assert property (p_iob_read)
		else $error("port b input bits not passed");

	property p_digit;
		@(posedge mclk) disable iff (!reset_n)
		wr_digit |=> (pins.digit_out_port == DIGIT_TABLE[$past(cpu_bus.wdata)*5 +: 5]);
	endproperty
	a_digit : assert property (p_digit)
		else $error("digit decode wrong");

	property p_key;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_DIGIT_KEY) |-> (rdata == key_in_port);
	endproperty
	a_key : assert property (p_key)
		else $error("key port read wrong");

	property p_seg;
		@(posedge mclk) disable iff (!reset_n)
		(wr_seg && !SEG_SPLIT) |=> (pins.segment_out_port == SEG_TABLE[$past(cpu_bus.wdata)*8 +: 8]);
	endproperty
	a_seg : assert property (p_seg)
		else $error("segment lookup wrong");

	property p_sync;
		@(posedge mclk) disable iff (!reset_n)
		half_tick |=> (in_sync[0] == $past(single_in_pin));
	endproperty
	a_sync : assert property (p_sync)
		else $error("input shaping stage not loaded");

	property p_cbuf;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_SEG_CBUF) |->
			(rdata[3:1] == {div_stages[TAP_3], div_stages[TAP_2], div_stages[TAP_1]});
	endproperty
	a_cbuf : assert property (p_cbuf)
		else $error("counter buffer taps wrong");

	property p_hold;
		@(posedge mclk) disable iff (!reset_n)
		hold_release_en == div_stages[TAP_3];
	endproperty
	a_hold : assert property (p_hold)
		else $error("hold release not from top tap");

	property p_ioa_read;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_IO_A) |->
			(rdata == (IO_A_IS_OUTPUT ? pins.cfg_io_port_a : io_a_in));
	endproperty
	a_ioa_read : assert property (p_ioa_read)
		else $error("port a read wrong");

	property p_iob_back;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_IO_B) |->
			((rdata & ~b_in_mask) == (pins.cfg_io_port_b & ~b_in_mask));
	endproperty
	a_iob_back : assert property (p_iob_back)
		else $error("port b output bits not read back");

	property p_seg_hi;
		@(posedge mclk) disable iff (!reset_n)
		wr_seg_hi |=> (pins.segment_out_port[7:4] == $past(cpu_bus.wdata));
	endproperty
	a_seg_hi : assert property (p_seg_hi)
		else $error("split high nibble not loaded");

	property p_seg_lo;
		@(posedge mclk) disable iff (!reset_n)
		(wr_seg && SEG_SPLIT) |=> (pins.segment_out_port[3:0] == $past(cpu_bus.wdata));
	endproperty
	a_seg_lo : assert property (p_seg_lo)
		else $error("split low nibble not loaded");

	property p_no_read7;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_SEG_HIGH) |-> (rdata == 4'h0);
	endproperty
	a_no_read7 : assert property (p_no_read7)
		else $error("segment high register readable");

	property p_rd_idle;
		@(posedge mclk) disable iff (!reset_n)
		!cpu_bus.rd |-> (rdata == 4'h0);
	endproperty
	a_rd_idle : assert property (p_rd_idle)
		else $error("read data without read strobe");

	property p_stray_wr;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.wr && ((cpu_bus.regnum inside {4'h0, 4'h3, [4'h8:4'hF]}) ||
			(cpu_bus.regnum == `PDU_REG_SEG_HIGH && !SEG_SPLIT))) |=> $stable(pins);
	endproperty
	a_stray_wr : assert property (p_stray_wr)
		else $error("write to unused number changed a pin");

	// two edges so a reset that opens the run is settled first
	property p_clear;
		@(posedge mclk) (!reset_n ##1 !reset_n) |-> (pins == '0);
	endproperty
	a_clear : assert property (p_clear)
		else $error("output registers not cleared in reset");

	property p_cbuf_pin;
		@(posedge mclk) disable iff (!reset_n)
		(cpu_bus.rd && cpu_bus.regnum == `PDU_REG_SEG_CBUF) |->
			(rdata[0] == in_sync[`PDU_SYNC_STAGES-1]);
	endproperty
	a_cbuf_pin : assert property (p_cbuf_pin)
		else $error("counter buffer pin bit wrong");

	c_seg_write  : cover property (@(posedge mclk) disable iff (!reset_n) wr_seg);
	c_digit_wr   : cover property (@(posedge mclk) disable iff (!reset_n) wr_digit);
	c_cbuf_read  : cover property (@(posedge mclk) disable iff (!reset_n)
		cpu_bus.rd && cpu_bus.regnum == `PDU_REG_SEG_CBUF);
	c_split_hi   : cover property (@(posedge mclk) disable iff (!reset_n) wr_seg_hi);
	c_key_read   : cover property (@(posedge mclk) disable iff (!reset_n)
		cpu_bus.rd && cpu_bus.regnum == `PDU_REG_DIGIT_KEY);
endmodule : pdu_port_unit

// File: tb_pdu_port_unit.sv
// testbench for the port unit: one split-port-b instance, one split-segment instance
// assumes the cpu model drives the shared bus; reset held 6 cycles
`timescale 1ns/1ps
module tb_pdu_port_unit;
	localparam logic [39:0]  DT = 40'h8C635A21F7;
	localparam logic [127:0] ST = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	logic               mclk, reset_n, pin, tpin, hold;
	logic [3:0]         ioa, iob, key, div_stage_10, q, oea, oeb, oea2, oeb2;
	logic [3:0]         v [4];
	pdu_pkg::pdu_bus_s  bus;
	pdu_pkg::pdu_pins_s pins, pins2;
	int                 failures, checks_done, cyc, n;
	pdu_cpu_model pdu_cpu_model_inst (.mclk(mclk), .cpu_bus(bus), .rdata(div_stage_10));
	pdu_port_unit #(.IO_A_IS_OUTPUT(1'b0), .IO_B_MODE(pdu_pkg::PDU_IOB_SPLIT),
		.DIGIT_TABLE(DT), .SEG_TABLE(ST)) pdu_port_unit_inst (
		.mclk(mclk), .reset_n(reset_n), .cpu_bus(bus), .rdata(div_stage_10), .io_a_in(ioa),
		.io_b_in(iob), .key_in_port(key), .single_in_pin(pin), .pins(pins),
		.io_a_oe(oea), .io_b_oe(oeb), .timing_out_pin(tpin), .hold_release_en(hold));
	// second build option: outputs only, segment split into two nibbles
	pdu_port_unit #(.SEG_SPLIT(1'b1)) pdu_port_unit_split_inst (
		.mclk(mclk), .reset_n(reset_n), .cpu_bus(bus), .rdata(), .io_a_in(ioa),
		.io_b_in(iob), .key_in_port(key), .single_in_pin(pin), .pins(pins2),
		.io_a_oe(oea2), .io_b_oe(oeb2), .timing_out_pin(), .hold_release_en());
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] r, input logic [3:0] d);
		pdu_cpu_model_inst.xfer(1'b1, r, d, q);
	endtask : wr
	task automatic rd(input logic [3:0] r);
		pdu_cpu_model_inst.xfer(1'b0, r, 4'h0, q);
	endtask : rd
	task automatic drive(input logic [3:0] a, input logic [3:0] b, input logic [3:0] k,
		input logic p);
		@(posedge mclk);
		#1;
		{ioa, iob, key, pin} = {a, b, k, p};
	endtask : drive
	// cycles between two changes of the timing pin (s=1) or hold enable (s=0)
	task automatic half(input bit s, output int m);
		logic h0;
		int   t0;
		for (int k = 0; k < 2; k++) begin
			h0 = s ? tpin : hold;
			t0 = cyc;
			while ((s ? tpin : hold) === h0 && cyc - t0 < 5000) begin
				@(posedge mclk);
				#1;
			end
		end
		m = cyc - t0;
	endtask : half
	task automatic t_reset();
		check("pins_a", pins, 32'h0);
		check("pins_b", pins2, 32'h0);
		check("oe_a", {oea, oeb}, 32'h03);
		check("oe_b", {oea2, oeb2}, 32'hFF);
	endtask : t_reset
	task automatic t_gen();
		v = '{4'hA, 4'h5, 4'h6, 4'hF};
		foreach (v[i]) begin
			wr(4'h1, v[i]);
			check("gen_pin", pins.gen_out_port, v[i]);
			rd(4'h1);
			check("gen_rd", q, v[i]);
		end
		wr(4'h3, 4'h0);
		wr(4'h8, 4'h0);
		check("gen_keep", pins.gen_out_port, 4'hF);
	endtask : t_gen
	task automatic t_io();
		drive(4'h9, 4'hD, 4'h3, 1'b0);
		rd(4'h2);
		check("io_a_rd", q, 4'h9);
		drive(4'h6, 4'hD, 4'h3, 1'b0);
		rd(4'h2);
		check("io_a_live", q, 4'h6);
		wr(4'h4, 4'h6);
		check("io_b_pin", pins.cfg_io_port_b[1:0], 2'b10);
		rd(4'h4);
		check("io_b_rd", q, 4'hE);
		wr(4'h2, 4'h9);
		check("io_a_out", pins2.cfg_io_port_a, 4'h9);
	endtask : t_io
	task automatic t_digit();
		for (int i = 0; i < 8; i++) begin
			wr(4'h5, i[3:0]);
			check("digit", pins.digit_out_port, DT[i*5+:5]);
		end
		rd(4'h5);
		check("key_rd", q, 4'h3);
		drive(4'h6, 4'hD, 4'hC, 1'b0);
		rd(4'h5);
		check("key_live", q, 4'hC);
	endtask : t_digit
	task automatic t_seg();
		for (int i = 0; i < 16; i++) begin
			wr(4'h6, i[3:0]);
			check("seg", pins.segment_out_port, ST[i*8+:8]);
			check("seg_lo", pins2.segment_out_port[3:0], i[3:0]);
		end
		wr(4'h7, 4'h5);
		check("seg_a_keep", pins.segment_out_port, ST[127:120]);
		check("seg_split", pins2.segment_out_port, 8'h5F);
		rd(4'h7);
		check("seg_rd", q, 4'h0);
	endtask : t_seg
	task automatic t_cbuf();
		drive(4'h6, 4'hD, 4'hC, 1'b1);
		repeat (2) @(posedge mclk);
		rd(4'h6);
		check("cbuf_pin1", q[0], 1'b1);
		drive(4'h6, 4'hD, 4'hC, 1'b0);
		repeat (2) @(posedge mclk);
		rd(4'h6);
		check("cbuf_pin0", q[0], 1'b0);
	endtask : t_cbuf
	task automatic t_div();
		half(1'b0, n);
		check("stage11_half", n, 4096);
		rd(4'h6);
		check("cbuf_taps", q[3:1], {hold, 2'b00});
		check("hold_en", q[3], hold);
		half(1'b1, n);
		check("timing_half", n, 64);
	endtask : t_div
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		{reset_n, ioa, iob, key, pin} = '0;
		{failures, checks_done, cyc} = '0;
		repeat (6) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_gen();
		t_io();
		t_digit();
		t_seg();
		t_cbuf();
		t_div();
		wrap_up();
	end
endmodule : tb_pdu_port_unit
